// ### src/dma_pkg.sv
package dma_pkg;
    // Sizes of the controller
    localparam int NCH            = 6;
    localparam int DW             = 16;
    localparam int ADR_W          = 12;
    localparam int LOW_GROUP_LAST = 3;

    // Module level register offsets (byte addresses)
    localparam logic [ADR_W-1:0] OFS_CON       = 12'h000;
    localparam logic [ADR_W-1:0] OFS_PMD       = 12'h004;
    localparam logic [ADR_W-1:0] OFS_UPPER     = 12'h008;
    localparam logic [ADR_W-1:0] OFS_LOWER     = 12'h00C;
    localparam logic [ADR_W-1:0] OFS_BUF       = 12'h010;
    localparam logic [ADR_W-1:0] OFS_IRQ_STAT  = 12'h014;
    localparam logic [ADR_W-1:0] OFS_IRQ_MASK  = 12'h018;

    // Channel register window: base, end, stride and offsets inside
    localparam logic [ADR_W-1:0] OFS_CH_BASE   = 12'h040;
    localparam logic [ADR_W-1:0] OFS_CH_END    = 12'h100;
    localparam logic [ADR_W-1:0] OFS_CH_MASK   = 12'h01F;
    localparam int               CH_IDX_LSB    = 5;
    localparam logic [ADR_W-1:0] OFS_CH_CTRL   = 12'h000;
    localparam logic [ADR_W-1:0] OFS_CH_INT    = 12'h004;
    localparam logic [ADR_W-1:0] OFS_CH_SRC    = 12'h008;
    localparam logic [ADR_W-1:0] OFS_CH_DST    = 12'h00C;
    localparam logic [ADR_W-1:0] OFS_CH_CNT    = 12'h010;

    // Field positions
    localparam int CON_EN_BIT    = 15;
    localparam int CON_PRS_BIT   = 0;
    localparam int PMD_LOW_BIT   = 4;
    localparam int PMD_HIGH_BIT  = 5;
    localparam int CH_EN_BIT     = 0;
    localparam int CH_SIZE_BIT   = 1;
    localparam int CH_TRM_LSB    = 2;
    localparam int CH_DAM_LSB    = 4;
    localparam int CH_SAM_LSB    = 6;
    localparam int INT_DONE_BIT  = 0;
    localparam int INT_ERR_BIT   = 1;
    localparam int TRM_REP_BIT   = 0;
    localparam int TRM_CONT_BIT  = 1;

    // Reset values
    localparam logic [DW-1:0] UPPER_RST    = 16'h0000;
    localparam logic [DW-1:0] LOWER_RST    = 16'h0000;
    localparam logic [2:0]    ARB_LAST_RST = 3'h5;

    // Pointer steps per element size
    localparam logic [DW-1:0] STEP_BYTE = 16'h0001;
    localparam logic [DW-1:0] STEP_WORD = 16'h0002;

    typedef enum logic [1:0] {
        TRM_ONESHOT     = 2'h0,
        TRM_REP_ONESHOT = 2'h1,
        TRM_CONT        = 2'h2,
        TRM_REP_CONT    = 2'h3
    } trmode_type;

    typedef enum logic [1:0] {
        AM_FIXED = 2'h0,
        AM_INC   = 2'h1,
        AM_DEC   = 2'h2,
        AM_PIA   = 2'h3
    } amode_type;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_READ  = 3'b010,
        ST_WRITE = 3'b100
    } fsm_type;
endpackage : dma_pkg

// ### src/arb_if.sv
`timescale 1ns/1ps
interface arb_if
    import dma_pkg::*;
    ();
    logic [NCH-1:0] req;
    logic [NCH-1:0] grant;
    logic [2:0]     grant_idx;
    logic           rr_mode;
    logic           take;

    modport engine  (output req, output rr_mode, output take,
                     input grant, input grant_idx);
    modport arbiter (input req, input rr_mode, input take,
                     output grant, output grant_idx);
endinterface : arb_if

// ### src/dma_arbiter.sv
`timescale 1ns/1ps
module dma_arbiter
    import dma_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    arb_if.arbiter    arb
);
    typedef struct packed {
        logic [2:0] last;
        logic       first;
    } arb_state_type;

    arb_state_type s_q;
    arb_state_type s_d;
    logic [2:0]    start;

    // First requester found when searching upward from start, wrapping
    function automatic logic [NCH-1:0] pick_from(input logic [NCH-1:0] req,
                                                 input logic [2:0] st);
        logic [NCH-1:0] g;
        int             k;
        g = '0;
        k = 0;
        for (int i = 0; i < NCH; i++) begin
            k = (int'(st) + i) % NCH;
            if (g == '0 && req[k]) begin
                g[k] = 1'b1;
            end
        end
        return g;
    endfunction : pick_from

    // Search start: after the last winner in round robin, else channel 0
    always_comb begin
        s_d = s_q;
        start = 3'h0;
        if (arb.rr_mode) begin // [RULE2]
            start = (s_q.last == 3'(NCH - 1)) ? 3'h0 : s_q.last + 3'h1;
        end
        arb.grant = pick_from(arb.req, start); // [RULE3]
        arb.grant_idx = 3'h0;
        for (int i = 0; i < NCH; i++) begin
            if (arb.grant[i]) begin
                arb.grant_idx = 3'(i);
            end
        end
        if (arb.take && arb.grant != '0) begin
            s_d.last = arb.grant_idx;
            s_d.first = 1'b0;
        end
    end

    // History reset points at the top channel so channel 0 searches first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q.last <= ARB_LAST_RST; // [RULE18]
            s_q.first <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    onehot_grant_a: assert property ( // [RULE1]
        (arb.req != '0) |->
            ($onehot(arb.grant) && (arb.grant & ~arb.req) == '0))
        else $error("grant not one-hot among requests");
    fixed_lowest_a: assert property ( // [RULE3]
        (!arb.rr_mode && arb.req != '0) |->
            arb.grant == (arb.req & (~arb.req + 6'h01)))
        else $error("fixed priority did not pick lowest");
    rr_first_a: assert property ( // [RULE18]
        (s_q.first && arb.req != '0) |->
            arb.grant == (arb.req & (~arb.req + 6'h01)))
        else $error("first collision not won by lowest channel");
    rr_rotate_a: assert property ( // [RULE2]
        (arb.rr_mode && !s_q.first && arb.take &&
         (arb.req & ~(6'h01 << s_q.last)) != '0) |->
            !arb.grant[s_q.last] ##1 (s_q.last == $past(arb.grant_idx)))
        else $error("round robin repeated last winner");
endmodule : dma_arbiter

// ### src/dma_channel_arbiter_setup.sv
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// RULE1: Channels run independently, sharing one bus
// RULE2: Round robin rotates grant upward after winners
// RULE3: Fixed priority always grants lowest channel
// RULE4: Enable bit and scheme select steer arbitration
// RULE5: Upper and lower limits bound RAM accesses
// RULE6: Software disables channel before reprogramming it
// RULE7: Each channel holds source and destination pointers
// RULE8: Count means triggers or elements by mode
// RULE9: Size bit selects word or byte elements
// RULE10: Mode field selects one-shot, continuous, repeated
// RULE11: Source/destination modes advance or hold pointers
// RULE12: Channel enable arms channel for triggers
// RULE13: Power-down acts only on channel groups
// RULE14: Low group bit powers down channels 0-3
// RULE15: High group bit powers down channels 4-5
// RULE16: Four module-level registers exist; the code decodes seven (OFS_CON to OFS_IRQ_MASK)
// RULE17: Each channel has five registers
// RULE18: Arbiter history cleared at reset
module dma_channel_arbiter_setup
    import dma_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [31:0]      wb_dat_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic             wb_we_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic [NCH-1:0]   trig_i,
    output logic                  mem_req_o,
    output logic                  mem_we_o,
    output logic                  mem_byte_o,
    output logic      [DW-1:0]    mem_addr_o,
    output logic      [DW-1:0]    mem_wdata_o,
    input  wire logic [DW-1:0]    mem_rdata_i,
    input  wire logic             mem_ack_i,
    output logic                  irq_o
);
    typedef struct packed {
        logic                   con_en;
        logic                   prs;
        logic                   pmd_low;
        logic                   pmd_high;
        logic [DW-1:0]          upper;
        logic [DW-1:0]          lower;
        logic [DW-1:0]          buffer;
        logic [2*NCH-1:0]       stat;
        logic [2*NCH-1:0]       mask;
        logic [NCH-1:0]         channel_enable;
        logic [NCH-1:0]         size;
        logic [NCH-1:0]         pend;
        logic [NCH-1:0][1:0]    trm;
        logic [NCH-1:0][1:0]    sam;
        logic [NCH-1:0][1:0]    dam;
        logic [NCH-1:0][DW-1:0] src;
        logic [NCH-1:0][DW-1:0] dst;
        logic [NCH-1:0][DW-1:0] cnt;
        logic [NCH-1:0][DW-1:0] src_base;
        logic [NCH-1:0][DW-1:0] dst_base;
        logic [NCH-1:0][DW-1:0] cnt_base;
        fsm_type                fsm;
        logic [2:0]             cur;
        logic                   ack;
        logic [DW-1:0]          rdat;
        logic [DW-1:0]          maddr;
        logic [DW-1:0]          mwdata;
        logic                   mwe;
    } state_type;

    typedef struct packed {
        logic             hit;
        logic [2:0]       idx;
        logic [ADR_W-1:0] ofs;
    } chan_sel_type;

    state_type      q;
    state_type      n;
    chan_sel_type   cs;
    logic [DW-1:0]  rv;
    logic [DW-1:0]  wv;
    logic [DW-1:0]  wm;
    logic           wr;
    logic [NCH-1:0] on;
    logic [2:0]     gi;
    logic           bad;
    logic           last_el;

    arb_if arb ();

    dma_arbiter u_arb (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .arb   (arb.arbiter)
    );

    // Map an address onto a channel number and register offset
    function automatic chan_sel_type chan_decode(input logic [ADR_W-1:0] a);
        chan_sel_type     r;
        logic [ADR_W-1:0] rel;
        rel = a - OFS_CH_BASE;
        r.hit = (a >= OFS_CH_BASE) && (a < OFS_CH_END);
        r.idx = 3'(rel >> CH_IDX_LSB);
        r.ofs = rel & OFS_CH_MASK;
        return r;
    endfunction : chan_decode

    // Byte lanes 0 and 1 replace the old value where selected
    function automatic logic [DW-1:0] lane_merge(input logic [DW-1:0] old,
                                                 input logic [DW-1:0] d,
                                                 input logic [1:0] sel);
        logic [DW-1:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = d[7:0];
        end
        if (sel[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction : lane_merge

    // A group bit removes power from its channels
    function automatic logic group_on(input logic lo, input logic hi,
                                      input int ch);
        return (ch <= LOW_GROUP_LAST) ? !lo : !hi;
    endfunction : group_on

    // Next pointer for an addressing mode; PERIPHERAL_INDIRECT_ADDRESSING keeps its base
    function automatic logic [DW-1:0] step_ptr(input logic [DW-1:0] p,
                                               input logic [1:0] m,
                                               input logic byte_el);
        logic [DW-1:0] s;
        s = byte_el ? STEP_BYTE : STEP_WORD;
        case (m)
            AM_INC:  return p + s;
            AM_DEC:  return p - s;
            default: return p;
        endcase
    endfunction : step_ptr

    // Group power state per channel
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            on[i] = group_on(q.pmd_low, q.pmd_high, i); // [RULE13]
        end
    end

    // Register file, transfer engine, triggers and power-down
    always_comb begin
        n = q;
        cs = chan_decode(wb_adr_i);
        rv = 16'h0000;
        gi = arb.grant_idx;
        bad = 1'b0;
        last_el = (q.cnt[q.cur] == 16'h0001) || (q.cnt[q.cur] == 16'h0000);
        // Readback mux, also the base of byte-lane writes
        if (cs.hit) begin
            case (cs.ofs) // [RULE17]
                OFS_CH_CTRL: begin
                    rv[CH_EN_BIT] = q.channel_enable[cs.idx];
                    rv[CH_SIZE_BIT] = q.size[cs.idx];
                    rv[CH_TRM_LSB+:2] = q.trm[cs.idx];
                    rv[CH_DAM_LSB+:2] = q.dam[cs.idx];
                    rv[CH_SAM_LSB+:2] = q.sam[cs.idx];
                end
                OFS_CH_INT: begin
                    rv[INT_DONE_BIT] = q.stat[cs.idx];
                    rv[INT_ERR_BIT] = q.stat[NCH+cs.idx];
                end
                OFS_CH_SRC: rv = q.src[cs.idx];
                OFS_CH_DST: rv = q.dst[cs.idx];
                OFS_CH_CNT: rv = q.cnt[cs.idx];
                default:    rv = 16'h0000;
            endcase
        end else begin
            case (wb_adr_i) // [RULE16]
                OFS_CON: begin
                    rv[CON_EN_BIT] = q.con_en;
                    rv[CON_PRS_BIT] = q.prs;
                end
                OFS_PMD: begin
                    rv[PMD_LOW_BIT] = q.pmd_low;
                    rv[PMD_HIGH_BIT] = q.pmd_high;
                end
                OFS_UPPER:    rv = q.upper;
                OFS_LOWER:    rv = q.lower;
                OFS_BUF:      rv = q.buffer;
                OFS_IRQ_STAT: rv = {4'h0, q.stat};
                OFS_IRQ_MASK: rv = {4'h0, q.mask};
                default:      rv = 16'h0000;
            endcase
        end
        wv = lane_merge(rv, wb_dat_i[15:0], wb_sel_i[1:0]);
        wm = lane_merge(16'h0000, wb_dat_i[15:0], wb_sel_i[1:0]);

        // Answer one cycle after the request; write lands on the ack edge
        n.ack = wb_cyc_i && wb_stb_i && !q.ack;
        if (!q.ack) begin
            n.rdat = rv;
        end
        wr = wb_cyc_i && wb_stb_i && wb_we_i && q.ack;
        if (wr && cs.hit) begin
            case (cs.ofs)
                OFS_CH_CTRL: begin
                    n.channel_enable[cs.idx] = wv[CH_EN_BIT]; // [RULE12]
                    if (!wv[CH_EN_BIT]) begin
                        n.pend[cs.idx] = 1'b0;
                    end
                    n.size[cs.idx] = wv[CH_SIZE_BIT]; // [RULE9]
                    n.trm[cs.idx] = wv[CH_TRM_LSB+:2]; // [RULE10]
                    n.dam[cs.idx] = wv[CH_DAM_LSB+:2]; // [RULE11]
                    n.sam[cs.idx] = wv[CH_SAM_LSB+:2]; // [RULE11]
                end
                OFS_CH_INT: begin
                    n.stat[cs.idx] = q.stat[cs.idx] & !wm[INT_DONE_BIT];
                    n.stat[NCH+cs.idx] = q.stat[NCH+cs.idx]
                                         & !wm[INT_ERR_BIT];
                end
                OFS_CH_SRC: begin
                    n.src[cs.idx] = wv; // [RULE7]
                    n.src_base[cs.idx] = wv;
                end
                OFS_CH_DST: begin
                    n.dst[cs.idx] = wv; // [RULE7]
                    n.dst_base[cs.idx] = wv;
                end
                OFS_CH_CNT: begin
                    n.cnt[cs.idx] = wv; // [RULE8]
                    n.cnt_base[cs.idx] = wv;
                end
                default: ;
            endcase
        end else if (wr) begin
            case (wb_adr_i)
                OFS_CON: begin
                    n.con_en = wv[CON_EN_BIT]; // [RULE4]
                    n.prs = wv[CON_PRS_BIT];
                end
                OFS_PMD: begin
                    n.pmd_low = wv[PMD_LOW_BIT]; // [RULE14]
                    n.pmd_high = wv[PMD_HIGH_BIT]; // [RULE15]
                end
                OFS_UPPER:    n.upper = wv; // [RULE5]
                OFS_LOWER:    n.lower = wv; // [RULE5]
                OFS_IRQ_STAT: n.stat = q.stat & ~wm[2*NCH-1:0];
                OFS_IRQ_MASK: n.mask = wv[2*NCH-1:0];
                default: ;
            endcase
        end

        // Requests only from idle, so a grant always starts a fresh element
        arb.rr_mode = !q.prs; // [RULE4]
        arb.req = q.channel_enable & q.pend & on
                  & {NCH{q.con_en && q.fsm == ST_IDLE}}; // [RULE1]
        arb.take = (q.fsm == ST_IDLE) && (arb.grant != '0);

        unique case (q.fsm)
            ST_IDLE: begin
                if (arb.take) begin
                    n.cur = gi;
                    // RAM side accesses must stay within the limits
                    bad = (q.sam[gi] != AM_PIA &&
                           (q.src[gi] < q.lower || q.src[gi] > q.upper))
                       || (q.dam[gi] != AM_PIA &&
                           (q.dst[gi] < q.lower || q.dst[gi] > q.upper));
                    if (bad) begin // [RULE5]
                        n.stat[NCH+gi] = 1'b1;
                        n.channel_enable[gi] = 1'b0;
                        n.pend[gi] = 1'b0;
                    end else begin
                        n.maddr = q.src[gi];
                        n.mwe = 1'b0;
                        n.fsm = ST_READ;
                    end
                end
            end
            ST_READ: begin
                if (mem_ack_i) begin
                    n.buffer = q.size[q.cur] ? {8'h00, mem_rdata_i[7:0]}
                                             : mem_rdata_i; // [RULE9]
                    n.mwdata = n.buffer;
                    n.maddr = q.dst[q.cur];
                    n.mwe = 1'b1;
                    n.fsm = ST_WRITE;
                end
            end
            ST_WRITE: begin
                if (mem_ack_i) begin
                    n.mwe = 1'b0;
                    n.fsm = ST_IDLE;
                    n.src[q.cur] = step_ptr(q.src[q.cur], q.sam[q.cur],
                                            q.size[q.cur]); // [RULE11]
                    n.dst[q.cur] = step_ptr(q.dst[q.cur], q.dam[q.cur],
                                            q.size[q.cur]); // [RULE11]
                    n.cnt[q.cur] = q.cnt[q.cur] - 16'h0001; // [RULE8]
                    if (last_el) begin
                        n.stat[q.cur] = 1'b1;
                        n.pend[q.cur] = 1'b0;
                        if (q.trm[q.cur][TRM_CONT_BIT]) begin // [RULE10]
                            n.src[q.cur] = q.src_base[q.cur];
                            n.dst[q.cur] = q.dst_base[q.cur];
                            n.cnt[q.cur] = q.cnt_base[q.cur];
                        end else begin
                            n.channel_enable[q.cur] = 1'b0;
                        end
                    end else if (!q.trm[q.cur][TRM_REP_BIT]) begin
                        // One element per trigger outside repeated modes
                        n.pend[q.cur] = 1'b0; // [RULE8]
                    end
                end
            end
            default: n.fsm = ST_IDLE;
        endcase

        // Triggers applied last so an arriving trigger wins over a clear
        for (int i = 0; i < NCH; i++) begin
            if (q.channel_enable[i] && on[i] && trig_i[i]) begin
                n.pend[i] = 1'b1; // [RULE12]
            end
            if (!on[i]) begin
                // Powered-down channels lose all their settings
                n.channel_enable[i] = 1'b0; // [RULE13]
                n.pend[i] = 1'b0;
                n.size[i] = 1'b0;
                n.trm[i] = 2'h0;
                n.sam[i] = 2'h0;
                n.dam[i] = 2'h0;
                n.src[i] = 16'h0000;
                n.dst[i] = 16'h0000;
                n.cnt[i] = 16'h0000;
                n.src_base[i] = 16'h0000;
                n.dst_base[i] = 16'h0000;
                n.cnt_base[i] = 16'h0000;
            end
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.fsm <= ST_IDLE;
            q.upper <= UPPER_RST;
            q.lower <= LOWER_RST;
        end else begin
            q <= n;
        end
    end

    // Outputs straight from the state register
    assign wb_ack_o = q.ack;
    assign wb_dat_o = {16'h0000, q.rdat};
    assign mem_req_o = (q.fsm == ST_READ) || (q.fsm == ST_WRITE);
    assign mem_we_o = q.mwe;
    assign mem_byte_o = q.size[q.cur];
    assign mem_addr_o = q.maddr;
    assign mem_wdata_o = q.mwdata;
    assign irq_o = |(q.stat & q.mask);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence elem_done_s;
        q.fsm == ST_WRITE && mem_ack_i && last_el;
    endsequence

    done_flag_a: assert property ( // [RULE8]
        elem_done_s |=> q.stat[$past(q.cur)])
        else $error("done flag not set after last element");
    oneshot_off_a: assert property ( // [RULE10]
        (elem_done_s and !q.trm[q.cur][TRM_CONT_BIT]) |=>
            !q.channel_enable[$past(q.cur)])
        else $error("one-shot channel stayed enabled");
    src_step_a: assert property ( // [RULE11]
        (q.fsm == ST_WRITE && mem_ack_i && !last_el &&
         q.sam[q.cur] == AM_INC) |=>
            q.src[$past(q.cur)] == $past(q.src[q.cur])
                + ($past(q.size[q.cur]) ? 16'h0001 : 16'h0002))
        else $error("source pointer step wrong");
    low_group_a: assert property ( // [RULE14]
        q.pmd_low |-> (arb.req[3:0] == 4'h0) ##1 (q.channel_enable[3:0] == 4'h0))
        else $error("low group active while powered down");
    high_group_a: assert property ( // [RULE15]
        q.pmd_high |-> (arb.req[5:4] == 2'h0) ##1 (q.channel_enable[5:4] == 2'h0))
        else $error("high group active while powered down");
    ctrl_off_a: assert property ( // [RULE4]
        (!q.con_en && q.fsm == ST_IDLE) |=> q.fsm == ST_IDLE)
        else $error("transfer started with controller disabled");
    limit_err_a: assert property ( // [RULE5]
        (arb.take && bad) |=> (q.stat[NCH+$past(gi)] && q.fsm == ST_IDLE))
        else $error("out of range access not refused");
    trig_arm_a: assert property ( // [RULE12]
        (q.channel_enable[0] && on[0] && trig_i[0]) |=> q.pend[0])
        else $error("trigger on armed channel lost");
    ack_pulse_a: assert property ( // [RULE16]
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not a one-cycle pulse");
endmodule : dma_channel_arbiter_setup

// ### verif/mem_model.sv
`timescale 1ns/1ps
module mem_model #(parameter int LAT = 2) (
    input  wire logic        clk_i,
    input  wire logic        req_i,
    input  wire logic [15:0] addr_i,
    output logic      [15:0] rdata_o = 16'h0000,
    output logic             ack_o = 1'b0
);
    int wait_q = 0;
    // Slow answer; idle data flips each cycle so stale reads show up
    always @(posedge clk_i) begin
        ack_o   <= 1'b0;
        rdata_o <= ~rdata_o;
        if (req_i && !ack_o) begin
            wait_q <= (wait_q == LAT) ? 0 : wait_q + 1;
            if (wait_q == LAT) begin
                ack_o   <= 1'b1;
                rdata_o <= addr_i ^ 16'h5A5A;
            end
        end
    end
endmodule : mem_model

// ### verif/dma_channel_arbiter_setup_tb.sv
`timescale 1ns/1ps
module dma_channel_arbiter_setup_tb;
    import dma_pkg::*;
    logic        clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0;
    logic        mreq, mwe, mack, ack, irq, mb, bx = 0;
    logic [11:0] adr = 0;
    logic [15:0] dat = 0, rdv, maddr, mwd, mrd;
    logic [5:0]  trig = 0;
    logic [31:0] dout;
    logic [11:0] ra [5] = '{12'h000, 12'h008, 12'h00C, 12'h200, 12'h040};
    int          err_count = 0, n_checks = 0, reqs = 0;
    dma_channel_arbiter_setup u_dma_channel_arbiter_setup (
        .clk_i, .rst_i, .wb_adr_i(adr), .wb_dat_i({16'h0000, dat}),
        .wb_sel_i(4'h3), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_dat_o(dout), .wb_ack_o(ack), .trig_i(trig), .mem_req_o(mreq),
        .mem_we_o(mwe), .mem_byte_o(mb), .mem_addr_o(maddr),
        .mem_wdata_o(mwd), .mem_rdata_i(mrd), .mem_ack_i(mack),
        .irq_o(irq));
    mem_model u_mem_model (.clk_i, .req_i(mreq), .addr_i(maddr),
        .rdata_o(mrd), .ack_o(mack));
    initial forever #5 clk_i = ~clk_i;
    // Counts rises of mem_req_o, one per element, to prove a refused element never starts
    always @(posedge mreq) reqs++;
    function automatic logic [15:0] sp(input int n);
        return 16'h0100 + 16'(n * 16);
    endfunction : sp
    function automatic logic [11:0] cb(input int n);
        return 12'h040 + 12'(n * 32);
    endfunction : cb
    task automatic chk(input string n, input logic [15:0] s, e);
        n_checks++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // One classic cycle; waits for ack, however late it comes
    task automatic wb(input logic [11:0] a, input logic w,
                      input logic [15:0] d);
        {adr, we, dat, cyc, stb} <= {a, w, d, 2'b11};
        do @(posedge clk_i); while (ack !== 1'b1);
        rdv = dout[15:0];
        {cyc, stb} <= 2'b00;
        @(posedge clk_i);
    endtask : wb
    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        wb(a, 1'b0, 16'h0000);
        chk($sformatf("reg %h", a), rdv, e);
    endtask : rd
    task automatic see(input logic w, input logic [15:0] a, d);
        do @(posedge clk_i); while (!(mreq === 1'b1 && mwe === w));
        chk("mem_addr_o", maddr, a);
        chk("mem_byte_o", 16'(mb), 16'(bx));
        if (w) chk("mem_wdata_o", mwd, d);
        do @(posedge clk_i); while (mack !== 1'b1);
    endtask : see
    // Two channels triggered in one cycle; a must be served before b
    task automatic race(input logic [5:0] m, input int a, b);
        trig <= m;
        @(posedge clk_i);
        trig <= 6'h00;
        see(1'b0, sp(a), 16'h0000);
        see(1'b1, sp(a) + 16'h0080, sp(a) ^ 16'h5A5A);
        see(1'b0, sp(b), 16'h0000);
        see(1'b1, sp(b) + 16'h0080, sp(b) ^ 16'h5A5A);
        repeat (3) @(posedge clk_i);
    endtask : race
    task automatic irq_step(input logic [11:0] a, input logic [15:0] d,
                            input logic e);
        wb(a, 1'b1, d);
        repeat (2) @(posedge clk_i);
        chk("irq_o", 16'(irq), 16'(e));
    endtask : irq_step
    task automatic summarize();
        if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    // Whole run needs a few hundred cycles; far more means a hang
    initial begin
        #100us;
        err_count++;
        summarize();
    end
    initial begin
        int r;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (ra[i]) rd(ra[i], 16'h0000);
        wb(12'h00C, 1'b1, 16'h0100);
        wb(12'h008, 1'b1, 16'h01CF);
        rd(12'h008, 16'h01CF);
        wb(12'h000, 1'b1, 16'h8000);
        for (int n = 0; n < NCH; n++) begin
            wb(cb(n), 1'b1, 16'h0000);
            wb(cb(n) + 12'h008, 1'b1, sp(n));
            wb(cb(n) + 12'h00C, 1'b1, sp(n) + 16'h0080);
            wb(cb(n) + 12'h010, 1'b1, 16'h0001);
            wb(cb(n), 1'b1, 16'h0059);
        end
        race(6'h03, 0, 1);
        race(6'h05, 2, 0);
        wb(12'h000, 1'b1, 16'h8001);
        race(6'h03, 0, 1);
        rd(12'h010, sp(1) ^ 16'h5A5A);
        // Channel 5 destination sits just past the upper limit
        r = reqs;
        trig <= 6'h20;
        @(posedge clk_i);
        trig <= 6'h00;
        repeat (10) @(posedge clk_i);
        chk("mem_req_o count", 16'(reqs), 16'(r));
        rd(12'h014, 16'h0807);
        rd(cb(5), 16'h0058);
        irq_step(12'h018, 16'h0000, 1'b0);
        irq_step(12'h018, 16'h0800, 1'b1);
        irq_step(12'h014, 16'h0800, 1'b0);
        rd(12'h014, 16'h0007);
        // Byte-wide repeated one-shot: one trigger moves both elements
        wb(cb(3), 1'b1, 16'h0000);
        wb(cb(3) + 12'h010, 1'b1, 16'h0002);
        wb(cb(3), 1'b1, 16'h0067);
        bx = 1'b1;
        trig <= 6'h08;
        @(posedge clk_i);
        trig <= 6'h00;
        see(1'b0, sp(3), 16'h0000);
        see(1'b1, sp(3) + 16'h0080, 16'h006A);
        see(1'b0, sp(3) + 16'h0001, 16'h0000);
        see(1'b1, sp(3) + 16'h007F, 16'h006B);
        repeat (3) @(posedge clk_i);
        rd(cb(3), 16'h0066);
        rd(cb(3) + 12'h010, 16'h0000);
        wb(12'h004, 1'b1, 16'h0010);
        rd(cb(0) + 12'h008, 16'h0000);
        rd(cb(4) + 12'h008, sp(4));
        wb(12'h004, 1'b1, 16'h0030);
        rd(cb(4) + 12'h008, 16'h0000);
        summarize();
    end
endmodule : dma_channel_arbiter_setup_tb
